// file: design/npiu_arbiter.sv
/*
 combinational arbiter: picks the enabled pending source with the best priority.
 assumes lower priority value wins, ties go to the lower source number.
*/
module npiu_arbiter #(
    parameter int N = npiu_pkg::NUM_IRQ
) (
    input wire logic [N-1:0] cand,
    input wire logic [N*npiu_pkg::PRIO_W-1:0] prio,
    output npiu_pkg::npiu_win_t win
);
    // ==========================================================
    // linear scan; strict less-than keeps the lowest index on ties
    always_comb
    begin
        win = '0;
        for (int i = 0; i < N; i++)
        begin
            if (cand[i] && (!win.valid ||
                prio[i*npiu_pkg::PRIO_W +: npiu_pkg::PRIO_W] < win.prio))
            begin
                win.valid = 1'b1;
                win.id = npiu_pkg::ID_W'(i);
                win.prio = prio[i*npiu_pkg::PRIO_W +: npiu_pkg::PRIO_W];
            end
        end
    end
endmodule // npiu_arbiter

// file: design/npiu_pkg.sv
/*
 package for the nested priority interrupt unit: register map, field widths, carriers.
 assumes an APB master with 32-bit data and word-aligned, full-word accesses.
*/
package npiu_pkg;
    // ==========================================================
    // sizes
    localparam int NUM_IRQ = 32;
    localparam int PRIO_W = 2;
    localparam int ID_W = 5;
    localparam int ADDR_W = 12;
    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_ENABLE_SET = 12'h000;
    localparam logic [11:0] OFS_ENABLE_CLR = 12'h004;
    localparam logic [11:0] OFS_PENDING_SET = 12'h008;
    localparam logic [11:0] OFS_PENDING_CLR = 12'h00c;
    localparam logic [11:0] OFS_PRIO_BASE = 12'h010;
    localparam logic [11:0] OFS_PRIO_LAST = 12'h02c;
    localparam logic [11:0] OFS_ACTIVE = 12'h030;
    localparam logic [11:0] OFS_ACK = 12'h034;
    localparam logic [11:0] OFS_EVT_STATUS = 12'h038;
    localparam logic [11:0] OFS_EVT_MASK = 12'h03c;
    // priority field: one byte lane per source, value in top bits of the byte
    localparam int PRIO_LANE_W = 8;
    localparam int PRIO_MSB = 7;
    localparam int PRIOS_PER_REG = 4;
    // ack register fields
    localparam int ACK_VALID_BIT = 31;
    // event status bits
    localparam int EVT_W = 2;
    localparam int EVT_NEW_WIN = 0;
    localparam int EVT_PREEMPT = 1;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic valid;
        logic [ID_W-1:0] id;
        logic [PRIO_W-1:0] prio;
    } npiu_win_t;
endpackage

// file: design/npiu_top.sv
/*
 nested priority interrupt unit: enables, pending, priorities, arbitration, core request.
 assumes APB master (core) doing full-word accesses and a synchronous ack write per service.
*/
// Our own choices: the placing of the registers and the APB register port.
// Functional notes
// - arbitrate peripheral requests, present winner to core
// - per-source programmable priority drives arbitration
// - registers are 32-bit words, little-endian
// - separate set and clear enable registers
// - pending held until cleared; set/clear pending
// - higher request replaces one under entry
module npiu_top #(
    parameter int N = npiu_pkg::NUM_IRQ
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [npiu_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N-1:0] irq_in,
    output logic core_irq_req,
    output logic [npiu_pkg::ID_W-1:0] core_irq_id,
    output logic evt_irq
);
    // ==========================================================
    // pin synchronisers
    logic [N-1:0] sync1_r, sync2_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= irq_in;
            sync2_r <= sync1_r;
        end
    end

    // ==========================================================
    // state
    logic [N-1:0] en_r, en_nxt, pend_r, pend_nxt, act_r, act_nxt;
    logic [N*npiu_pkg::PRIO_W-1:0] prio_r, prio_nxt;
    logic [npiu_pkg::EVT_W-1:0] est_r, est_nxt, emsk_r, emsk_nxt;
    logic req_r, req_nxt;
    logic [npiu_pkg::ID_W-1:0] id_r, id_nxt;
    logic [31:0] rdata_nxt;
    logic perr_nxt, evt_nxt, rdy_nxt;
    npiu_pkg::npiu_win_t win;

    npiu_arbiter #(.N(N)) u_arb (
        .cand(pend_r & en_r),
        .prio(prio_r),
        .win(win)
    );

    // ==========================================================
    // bus decode helpers
    function automatic logic prio_hit(input logic [npiu_pkg::ADDR_W-1:0] a);
        prio_hit = a >= npiu_pkg::OFS_PRIO_BASE && a <= npiu_pkg::OFS_PRIO_LAST
                   && a[1:0] == 2'b00;
    endfunction

    logic acc, wr, rd, take;
    logic [npiu_pkg::ADDR_W-1:0] pidx;
    assign acc = psel && penable && !pready;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    // core takes the offered source: ack write with the end-of-service bit low
    assign take = wr && paddr == npiu_pkg::OFS_ACK && !pwdata[npiu_pkg::ACK_VALID_BIT]
                  && req_r;
    assign pidx = (paddr - npiu_pkg::OFS_PRIO_BASE) >> 2;

    // ==========================================================
    // next state
    always_comb
    begin
        en_nxt = en_r;
        pend_nxt = pend_r;
        act_nxt = act_r;
        prio_nxt = prio_r;
        est_nxt = est_r;
        emsk_nxt = emsk_r;
        req_nxt = req_r;
        id_nxt = id_r;
        rdata_nxt = npiu_pkg::ZERO_WORD;
        perr_nxt = 1'b0;
        rdy_nxt = acc; // one wait state: answer on the second access cycle
        if (wr)
        begin
            unique case (paddr)
                npiu_pkg::OFS_ENABLE_SET: en_nxt = en_r | pwdata[N-1:0];
                npiu_pkg::OFS_ENABLE_CLR: en_nxt = en_r & ~pwdata[N-1:0];
                npiu_pkg::OFS_PENDING_SET: pend_nxt = pend_r | pwdata[N-1:0];
                npiu_pkg::OFS_PENDING_CLR: pend_nxt = pend_r & ~pwdata[N-1:0];
                npiu_pkg::OFS_ACK:
                    if (pwdata[npiu_pkg::ACK_VALID_BIT])
                        act_nxt = act_r & ~(N'(1) << pwdata[npiu_pkg::ID_W-1:0]);
                npiu_pkg::OFS_EVT_STATUS: est_nxt = est_r & ~pwdata[npiu_pkg::EVT_W-1:0];
                npiu_pkg::OFS_EVT_MASK: emsk_nxt = pwdata[npiu_pkg::EVT_W-1:0];
                default:
                    if (prio_hit(paddr))
                    begin
                        for (int k = 0; k < npiu_pkg::PRIOS_PER_REG; k++)
                        begin
                            // little-endian: byte k of the word is source 4*idx+k
                            prio_nxt[(pidx*npiu_pkg::PRIOS_PER_REG+k)*npiu_pkg::PRIO_W
                                     +: npiu_pkg::PRIO_W] =
                                pwdata[k*npiu_pkg::PRIO_LANE_W + npiu_pkg::PRIO_MSB
                                       -: npiu_pkg::PRIO_W];
                        end
                    end
                    else
                    begin
                        perr_nxt = 1'b1;
                    end
            endcase
        end
        if (rd)
        begin
            unique case (paddr)
                npiu_pkg::OFS_ENABLE_SET, npiu_pkg::OFS_ENABLE_CLR:
                    rdata_nxt[N-1:0] = en_r;
                npiu_pkg::OFS_PENDING_SET, npiu_pkg::OFS_PENDING_CLR:
                    rdata_nxt[N-1:0] = pend_r;
                npiu_pkg::OFS_ACTIVE: rdata_nxt[N-1:0] = act_r;
                npiu_pkg::OFS_ACK:
                begin
                    rdata_nxt[npiu_pkg::ACK_VALID_BIT] = req_r;
                    rdata_nxt[npiu_pkg::ID_W-1:0] = id_r;
                end
                npiu_pkg::OFS_EVT_STATUS: rdata_nxt[npiu_pkg::EVT_W-1:0] = est_r;
                npiu_pkg::OFS_EVT_MASK: rdata_nxt[npiu_pkg::EVT_W-1:0] = emsk_r;
                default:
                    if (prio_hit(paddr))
                    begin
                        for (int k = 0; k < npiu_pkg::PRIOS_PER_REG; k++)
                        begin
                            rdata_nxt[k*npiu_pkg::PRIO_LANE_W + npiu_pkg::PRIO_MSB
                                      -: npiu_pkg::PRIO_W] =
                                prio_r[(pidx*npiu_pkg::PRIOS_PER_REG+k)*npiu_pkg::PRIO_W
                                       +: npiu_pkg::PRIO_W];
                        end
                    end
                    else
                    begin
                        perr_nxt = 1'b1;
                    end
            endcase
        end
        // ack taken by the core: source becomes active, pending cleared
        if (take)
        begin
            act_nxt[id_r] = 1'b1;
            pend_nxt[id_r] = 1'b0;
            req_nxt = 1'b0;
        end
        // hardware sets after software clears, so a same-cycle edge is not lost
        pend_nxt = pend_nxt | sync2_r;
        // withdraw first, so a worse source still pending can take the freed slot
        if (req_nxt && !(pend_r[id_r] && en_r[id_r]))
            req_nxt = 1'b0; // withdrawn by disable or clear-pending
        // the acked source still sits in pend_r this cycle: offer again one cycle later
        // active bits are informational only and do not gate the offer
        if (win.valid && !take)
        begin
            if (!req_nxt)
            begin
                req_nxt = 1'b1;
                id_nxt = win.id;
                est_nxt[npiu_pkg::EVT_NEW_WIN] = 1'b1;
            end
            else if (win.id != id_r &&
                     win.prio < prio_r[id_r*npiu_pkg::PRIO_W +: npiu_pkg::PRIO_W])
            begin
                id_nxt = win.id; // late arrival overtakes entry in progress
                est_nxt[npiu_pkg::EVT_PREEMPT] = 1'b1;
            end
        end
        evt_nxt = |(est_nxt & emsk_nxt);
    end

    // ==========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_r <= '0;
            pend_r <= '0;
            act_r <= '0;
            prio_r <= '0;
            est_r <= '0;
            emsk_r <= '0;
            req_r <= 1'b0;
            id_r <= '0;
            prdata <= npiu_pkg::ZERO_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
            core_irq_req <= 1'b0;
            core_irq_id <= '0;
            evt_irq <= 1'b0;
        end
        else
        begin
            en_r <= en_nxt;
            pend_r <= pend_nxt;
            act_r <= act_nxt;
            prio_r <= prio_nxt;
            est_r <= est_nxt;
            emsk_r <= emsk_nxt;
            req_r <= req_nxt;
            id_r <= id_nxt;
            prdata <= rdata_nxt;
            pready <= rdy_nxt;
            pslverr <= perr_nxt;
            core_irq_req <= req_nxt;
            core_irq_id <= id_nxt;
            evt_irq <= evt_nxt;
        end
    end
endmodule // npiu_top

// file: test/npiu_chk.sv
/*
 checker: apb answer timing and core request behaviour at npiu_top ports.
 assumes one clock pclk and async active-low presetn.
*/
module npiu_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_irq_req,
    input wire logic evt_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done;
    assign done = psel && penable && pready && pwrite;
    sequence s_ack;
        done && paddr == npiu_pkg::OFS_ACK && !pwdata[31];
    endsequence
    sequence s_dis;
        done && paddr == npiu_pkg::OFS_ENABLE_CLR && pwdata == 32'hffff_ffff;
    endsequence
    property p_wait; psel && penable && !pready |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_idle; !pready |-> prdata == npiu_pkg::ZERO_WORD; endproperty
    property p_unmap; psel && penable && pready && paddr > 12'h03c |-> pslverr; endproperty
    property p_ack; s_ack |-> ##[0:1] !core_irq_req; endproperty
    property p_dis; s_dis |-> ##[1:3] !core_irq_req; endproperty
    // no write in three cycles means nothing can have withdrawn the request
    property p_hold;
        core_irq_req && !psel && !$past(psel) && !$past(psel, 2) |=> core_irq_req;
    endproperty
    property p_mask;
        done && paddr == npiu_pkg::OFS_EVT_MASK && pwdata == 32'h0000_0000 |-> ##[1:2] !evt_irq;
    endproperty
    a_wait: assert property (p_wait) else $error("access not answered");
    a_pulse: assert property (p_pulse) else $error("ready too long");
    a_idle: assert property (p_idle) else $error("read data not zero");
    a_unmap: assert property (p_unmap) else $error("no slave error");
    a_ack: assert property (p_ack) else $error("request kept after ack");
    a_dis: assert property (p_dis) else $error("disabled source offered");
    a_hold: assert property (p_hold) else $error("request dropped");
    a_mask: assert property (p_mask) else $error("masked event raised");
endmodule // npiu_chk
bind npiu_top npiu_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .core_irq_req, .evt_irq);

// file: test/npiu_src.sv
/*
 peripheral line model: holds each request level until the bench drops it.
 assumes lines change only at a rising pclk edge.
*/
module npiu_src (
    input wire logic pclk,
    input wire logic [31:0] lvl,
    output logic [31:0] irq
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // request lines
    always_ff @(posedge pclk)
    begin
        irq <= lvl;
    end
endmodule // npiu_src

// file: test/npiu_tb_top.sv
/*
 bench: apb tasks drive registers, line model drives requests, core outputs compared.
 assumes npiu_top with 32 sources and one wait state per access.
*/
module npiu_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] lvl = 32'h0000_0000;
    logic [31:0] prdata, irq_in, q;
    logic pready, pslverr, core_irq_req, evt_irq, err;
    logic [4:0] core_irq_id;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #2.5 pclk = ~pclk;
    npiu_src src_u (.pclk(pclk), .lvl(lvl), .irq(irq_in));
    npiu_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq_in, .core_irq_req, .core_irq_id, .evt_irq);
    // ====================
    // tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // starts one edge late so release and the next setup never share a time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        check(q, e);
    endtask
    task automatic offer(input int n, input logic [31:0] e);
        repeat (n) @(posedge pclk);
        check(32'({core_irq_req, core_irq_id}), e);
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ====================
    // tests
    initial
    begin
        #20000;
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 64; a += 4)
            rd(12'(a), 32'h0000_0000);
        rd(12'h040, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        apb(1'b1, npiu_pkg::OFS_ENABLE_SET, 32'h0000_0005);
        apb(1'b1, npiu_pkg::OFS_ENABLE_SET, 32'h0000_0000);
        rd(npiu_pkg::OFS_ENABLE_SET, 32'h0000_0005);
        apb(1'b1, npiu_pkg::OFS_PRIO_BASE, 32'h0000_00c0);
        rd(npiu_pkg::OFS_PRIO_BASE, 32'h0000_00c0);
        lvl <= 32'h0000_0001;
        offer(6, 32'h0000_0020);
        lvl <= 32'h0000_0004;
        offer(6, 32'h0000_0022);
        lvl <= 32'h0000_0000;
        rd(npiu_pkg::OFS_EVT_STATUS, 32'h0000_0003);
        apb(1'b1, npiu_pkg::OFS_EVT_MASK, 32'h0000_0003);
        offer(2, 32'h0000_0022);
        check(32'(evt_irq), 32'h0000_0001);
        apb(1'b1, npiu_pkg::OFS_EVT_STATUS, 32'h0000_0003);
        rd(npiu_pkg::OFS_EVT_STATUS, 32'h0000_0000);
        apb(1'b1, npiu_pkg::OFS_ACK, 32'h0000_0000);
        offer(3, 32'h0000_0020);
        rd(npiu_pkg::OFS_ACK, 32'h8000_0000);
        rd(npiu_pkg::OFS_ACTIVE, 32'h0000_0004);
        apb(1'b1, npiu_pkg::OFS_ACK, 32'h8000_0002);
        rd(npiu_pkg::OFS_ACTIVE, 32'h0000_0000);
        rd(npiu_pkg::OFS_PENDING_SET, 32'h0000_0001);
        apb(1'b1, npiu_pkg::OFS_PENDING_CLR, 32'h0000_0001);
        offer(3, 32'h0000_0000);
        apb(1'b1, npiu_pkg::OFS_PENDING_SET, 32'h0000_0004);
        offer(3, 32'h0000_0022);
        apb(1'b1, npiu_pkg::OFS_ENABLE_CLR, 32'hffff_ffff);
        offer(3, 32'h0000_0002);
        rd(npiu_pkg::OFS_PENDING_SET, 32'h0000_0004);
        apb(1'b1, npiu_pkg::OFS_EVT_MASK, 32'h0000_0000);
        check(32'(evt_irq), 32'h0000_0000);
        offer(3, 32'h0000_0002);
        end_sim();
    end
endmodule // npiu_tb_top
